// *** sfe_fifo.sv ***
/*
   Flip-flop FIFO with valid/ready on both sides.
   Assumes one clock and a synchronous active-low reset.
*/
module sfe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   sfe_stream_if.snk in_s,
   sfe_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW:0] wp_q, wp_d, rp_q, rp_d;
   logic push, pop, full, empty;

   // ---------------------------------------------------------------
   // Pointer arithmetic; one extra bit tells full from empty.
   // ---------------------------------------------------------------
   assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign empty = (wp_q == rp_q);
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem_q[rp_q[AW-1:0]];
   assign push = in_s.valid && !full;
   assign pop = out_s.ready && !empty;

   // Next pointer and storage values.
   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (push) begin
         mem_d[wp_q[AW-1:0]] = in_s.data;
      end
   end

   // Registers only; storage needs no reset.
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
      mem_q <= mem_d;
   end
endmodule

// *** sfe_front_end.sv ***
/*
   Serial flash front end: select framing, link sampling, output
   launch, header decode, data buffering and internal cycle timing.
   Assumes the link pins are asynchronous and that the link clock
   is slow enough (80 ns or more) to be oversampled by the system clock.
*/
module sfe_front_end #(
   parameter int PROG_CYCLES = sfe_pkg::PROG_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_sel_n,
   input wire logic i_sck,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   input wire logic i_cfg_256,
   input wire logic i_timed_op,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_req,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd,
   output logic [9:0] o_page,
   output logic [8:0] o_col,
   output logic o_page_256,
   output logic o_sec_user,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   output logic o_overrun,
   output logic [8:0] o_prog_count,
   output logic o_busy,
   output logic o_standby
);
   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   logic [2:0] meta_q, sync_q, old_q;
   logic sel_n, sck, si, sck_old, sel_old;
   logic rise, fall, frame_start, frame_end;

   // The first stage is read only by the second.
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
         old_q <= 3'h7;
      end else begin
         meta_q <= {i_sel_n, i_sck, i_si};
         sync_q <= meta_q;
         old_q <= sync_q;
      end
   end

   assign sel_n = sync_q[2];
   assign sck = sync_q[1];
   assign si = sync_q[0];
   assign sel_old = old_q[2];
   assign sck_old = old_q[1];
   // Edges only count while selected, so the idle level is irrelevant.
   assign rise = !sel_n && sck && !sck_old;
   assign fall = !sel_n && !sck && sck_old;
   assign frame_start = !sel_n && sel_old;
   assign frame_end = sel_n && !sel_old;

   // ---------------------------------------------------------------
   // Page geometry decode, shared by address and count logic.
   // ---------------------------------------------------------------
   function automatic logic [8:0] page_len(input logic short_page);
      page_len = short_page ? sfe_pkg::PAGE_SHORT : sfe_pkg::PAGE_LONG;
   endfunction

   function automatic logic [9:0] page_of(input logic [23:0] a, input logic s);
      page_of = s ? a[17:8] : a[18:9];
   endfunction

   function automatic logic [8:0] col_of(input logic [23:0] a, input logic s);
      col_of = s ? {1'b0, a[7:0]} : a[8:0];
   endfunction

   // ---------------------------------------------------------------
   // Frame state, shifting and header capture.
   // ---------------------------------------------------------------
   sfe_pkg::sfe_state_type st_q, st_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] rx_q, rx_d;
   logic [1:0] abyte_q, abyte_d;
   logic [23:0] addr_q, addr_d;
   logic [7:0] cmd_q, cmd_d;
   logic cmd_v_q, cmd_v_d;
   logic [8:0] col_q, col_d;
   logic [8:0] cnt_q, cnt_d;
   logic push_q, push_d;
   logic [7:0] push_data_q, push_data_d;
   logic [7:0] tx_q, tx_d;
   logic seen_rise_q, seen_rise_d;
   logic tx_req_q, tx_req_d;
   logic page_256_q, page_256_d;
   logic ovr_q, ovr_d;
   logic [7:0] nbyte;
   logic byte_done;

   // Stream carriers to the receive buffer, declared before the framing logic reads them.
   sfe_stream_if fifo_in ();
   sfe_stream_if fifo_out ();

   assign nbyte = {rx_q[6:0], si};
   assign byte_done = rise && (bit_q == 3'h7);

   // Next-value logic for the framing path.
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      rx_d = rx_q;
      abyte_d = abyte_q;
      addr_d = addr_q;
      cmd_d = cmd_q;
      cmd_v_d = 1'b0;
      col_d = col_q;
      cnt_d = cnt_q;
      push_d = 1'b0;
      push_data_d = push_data_q;
      tx_d = tx_q;
      seen_rise_d = seen_rise_q;
      tx_req_d = 1'b0;
      page_256_d = page_256_q | i_cfg_256;
      ovr_d = ovr_q;
      if (frame_start) begin
         st_d = sfe_pkg::SFE_CMD;
         bit_d = 3'h0;
         abyte_d = 2'h0;
         cnt_d = 9'h000;
         tx_d = 8'h00;
         seen_rise_d = 1'b0;
         ovr_d = 1'b0;
      end else if (sel_n) begin
         st_d = sfe_pkg::SFE_IDLE;
      end else begin
         if (rise) begin
            rx_d = nbyte;
            bit_d = bit_q + 3'h1;
            seen_rise_d = 1'b1;
         end
         // A fall before any rise (idle-high clock) launches nothing.
         if (fall && seen_rise_q) begin
            if (bit_q == 3'h0) begin
               tx_d = i_tx_data;
               tx_req_d = 1'b1;
            end else begin
               tx_d = {tx_q[6:0], 1'b0};
            end
         end
         if (byte_done) begin
            unique case (st_q)
               sfe_pkg::SFE_IDLE: begin
                  st_d = sfe_pkg::SFE_IDLE;
               end
               sfe_pkg::SFE_CMD: begin
                  cmd_d = nbyte;
                  cmd_v_d = 1'b1;
                  st_d = sfe_pkg::SFE_ADDR;
               end
               sfe_pkg::SFE_ADDR: begin
                  addr_d = {addr_q[15:0], nbyte};
                  abyte_d = abyte_q + 2'h1;
                  if (abyte_q == 2'(sfe_pkg::ADDR_BYTES - 1)) begin
                     col_d = col_of({addr_q[15:0], nbyte}, page_256_q);
                     st_d = sfe_pkg::SFE_DATA;
                  end
               end
               sfe_pkg::SFE_DATA: begin
                  push_d = 1'b1;
                  push_data_d = nbyte;
                  // Column wraps inside the page, as a page buffer does.
                  if (col_q == page_len(page_256_q) - 9'h001) begin
                     col_d = 9'h000;
                  end else begin
                     col_d = col_q + 9'h001;
                  end
                  // Count saturates at one full page.
                  if (cnt_q != page_len(page_256_q)) begin
                     cnt_d = cnt_q + 9'h001;
                  end
               end
            endcase
         end
      end
      if (push_q && !fifo_in.ready) begin
         ovr_d = 1'b1;
      end
   end

   // Registers for the framing path.
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         st_q <= sfe_pkg::SFE_IDLE;
         bit_q <= 3'h0;
         rx_q <= 8'h00;
         abyte_q <= 2'h0;
         addr_q <= 24'h000000;
         cmd_q <= 8'h00;
         cmd_v_q <= 1'b0;
         col_q <= 9'h000;
         cnt_q <= 9'h000;
         push_q <= 1'b0;
         push_data_q <= 8'h00;
         tx_q <= 8'h00;
         seen_rise_q <= 1'b0;
         tx_req_q <= 1'b0;
         page_256_q <= sfe_pkg::PAGE_256_RESET;
         ovr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         abyte_q <= abyte_d;
         addr_q <= addr_d;
         cmd_q <= cmd_d;
         cmd_v_q <= cmd_v_d;
         col_q <= col_d;
         cnt_q <= cnt_d;
         push_q <= push_d;
         push_data_q <= push_data_d;
         tx_q <= tx_d;
         seen_rise_q <= seen_rise_d;
         tx_req_q <= tx_req_d;
         page_256_q <= page_256_d;
         ovr_q <= ovr_d;
      end
   end

   // ---------------------------------------------------------------
   // Self-timed cycle and standby.
   // ---------------------------------------------------------------
   logic [31:0] tmr_q, tmr_d;
   logic busy_q, busy_d;
   logic armed_q, armed_d;

   // The cycle starts only when select ends a self-timed command, so
   // the host never has to clock the device through it.
   always_comb begin
      tmr_d = tmr_q;
      busy_d = busy_q;
      armed_d = armed_q;
      if (frame_start) begin
         armed_d = 1'b0;
      end
      if (cmd_v_q) begin
         armed_d = i_timed_op;
      end
      if (frame_end && armed_q && !busy_q) begin
         busy_d = 1'b1;
         tmr_d = 32'(PROG_CYCLES - 1);
         armed_d = 1'b0;
      end else if (busy_q) begin
         if (tmr_q == 32'h00000000) begin
            busy_d = 1'b0;
         end else begin
            tmr_d = tmr_q - 32'h00000001;
         end
      end
   end

   // Registers for the cycle timer.
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         tmr_q <= 32'h00000000;
         busy_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         tmr_q <= tmr_d;
         busy_q <= busy_d;
         armed_q <= armed_d;
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer; it keeps filling while a cycle runs.
   // ---------------------------------------------------------------
   assign fifo_in.valid = push_q;
   assign fifo_in.data = push_data_q;
   assign fifo_out.ready = i_rx_ready;

   sfe_fifo #(
      .WIDTH(sfe_pkg::FIFO_WIDTH),
      .DEPTH(sfe_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .in_s(fifo_in),
      .out_s(fifo_out)
   );

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   // Output line is driven only while selected; released otherwise.
   assign o_so_oe = !sel_n;
   assign o_so = tx_q[7];
   assign o_tx_req = tx_req_q;
   assign o_cmd_valid = cmd_v_q;
   assign o_cmd = cmd_q;
   assign o_page = page_of(addr_q, page_256_q);
   assign o_col = col_q;
   assign o_page_256 = page_256_q;
   // Only the upper half of the security area is user writable.
   assign o_sec_user = (addr_q[23:7] == 17'h00000) &&
      (addr_q[6:0] >= sfe_pkg::SEC_USER_BASE);
   assign o_rx_valid = fifo_out.valid;
   assign o_rx_data = fifo_out.data;
   assign o_overrun = ovr_q;
   assign o_prog_count = cnt_q;
   assign o_busy = busy_q;
   // Standby is deferred while a self-timed cycle is still running.
   // The delayed select hides the one cycle before busy is registered.
   assign o_standby = sel_n && sel_old && !busy_q;
endmodule

// *** sfe_front_end_properties.sv ***
/*
   Checker for the serial flash front end: framing, deselect,
   timed cycle and page bounds. Assumes it is bound to sfe_front_end.
*/
module sfe_front_end_props #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_sel_n,
   input wire logic i_cfg_256,
   input wire logic o_so_oe,
   input wire logic o_tx_req,
   input wire logic o_cmd_valid,
   input wire logic o_page_256,
   input wire logic [8:0] o_col,
   input wire logic [8:0] o_prog_count,
   input wire logic o_busy,
   input wire logic o_standby
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   int busy_cnt_q;
   int busy_cnt_d;
   // ---------------------------------------------------------------
   // Busy length counter.
   // ---------------------------------------------------------------
   // Counts consecutive busy cycles, so the length check needs no long repetition.
   always_comb begin
      busy_cnt_d = o_busy ? busy_cnt_q + 1 : 0;
   end
   // Registers the busy counter.
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         busy_cnt_q <= 0;
      end else begin
         busy_cnt_q <= busy_cnt_d;
      end
   end
   // ---------------------------------------------------------------
   // Properties.
   // ---------------------------------------------------------------
   a_oe_off: assert property (i_sel_n [*4] |-> !o_so_oe)
      else $error("output driven while deselected");
   a_desel_quiet: assert property (i_sel_n [*4] |-> !o_cmd_valid && !o_tx_req)
      else $error("activity while deselected");
   a_sel_active: assert property (!i_sel_n [*4] |-> !o_standby)
      else $error("standby while selected");
   a_busy_awake: assert property (o_busy |-> !o_standby)
      else $error("standby during timed cycle");
   a_busy_no_gap: assert property ($rose(o_busy) |-> !$past(o_standby))
      else $error("standby before timed cycle");
   a_busy_len: assert property ($fell(o_busy) |-> busy_cnt_q == PROG_CYCLES)
      else $error("timed cycle length wrong");
   a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
      else $error("opcode strobe too long");
   a_page_cause: assert property ($rose(o_page_256) |-> $past(i_cfg_256) || $past(i_cfg_256, 2))
      else $error("page mode changed without request");
   a_page_keep: assert property (o_page_256 |=> o_page_256)
      else $error("page mode not sticky");
   a_col_bound: assert property (o_col < (o_page_256 ? 9'h100 : 9'h108))
      else $error("column beyond page");
   a_count_sat: assert property (o_prog_count <= (o_page_256 ? 9'h100 : 9'h108))
      else $error("byte count beyond page");
   c_busy: cover property ($rose(o_busy));
   c_page: cover property ($rose(o_page_256));
   c_cmd: cover property (o_cmd_valid);
endmodule
bind sfe_front_end sfe_front_end_props #(.PROG_CYCLES(PROG_CYCLES)) sfe_front_end_props_inst (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sel_n(i_sel_n), .i_cfg_256(i_cfg_256),
   .o_so_oe(o_so_oe), .o_tx_req(o_tx_req), .o_cmd_valid(o_cmd_valid),
   .o_page_256(o_page_256), .o_col(o_col), .o_prog_count(o_prog_count),
   .o_busy(o_busy), .o_standby(o_standby));

// *** sfe_host_model.sv ***
/*
   Link host model: select, link clock at 80 ns and serial data.
   Assumes the caller runs its tasks from the system clock domain.
*/
module sfe_host_model (
   input wire logic i_sys_clk,
   input wire logic i_so,
   output logic o_sel_n,
   output logic o_sck,
   output logic o_si
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels at time zero; outside frames the clock moves only in wiggle and frame_start.
   initial begin
      o_sel_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end
   // Opens a frame with the clock idling at the mode's level.
   task automatic frame_start(input logic m3);
      @(posedge i_sys_clk) o_sck <= m3;
      repeat (4) @(posedge i_sys_clk);
      o_sel_n <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
   endtask
   // One byte, MSB first: data set while low, rise after half a period.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge i_sys_clk) o_sck <= 1'b0;
         o_si <= tx[i];
         repeat (4) @(posedge i_sys_clk);
         o_sck <= 1'b1;
         repeat (3) @(posedge i_sys_clk);
         rx[i] = i_so; // Sampled late in the high phase, well after the launch.
      end
   endtask
   // Closes a frame; the data line then shows the inverse, not a held value.
   task automatic frame_end(input logic m3);
      @(posedge i_sys_clk) if (!m3) o_sck <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      o_sel_n <= 1'b1;
      o_si <= ~o_si;
      repeat (4) @(posedge i_sys_clk);
   endtask
   // Toggles clock and data while deselected.
   task automatic wiggle(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_sys_clk) o_sck <= ~o_sck;
         o_si <= ~o_si;
         repeat (3) @(posedge i_sys_clk);
      end
   endtask
endmodule

// *** sfe_pkg.sv ***
/*
   Constants shared by the serial flash front end: framing, page
   layout, security area, FIFO shape and internal cycle timing.
   Assumes a 100 MHz system clock that oversamples the serial link.
*/
// Notes on behaviour
// - Select fall starts, rise ends each frame.
// - Deselected means standby, output line released.
// - Deselected device ignores serial input entirely.
// - Standby waits for self-timed cycle completion.
// - Input bits sampled on serial clock rise.
// - Output bits launched on serial clock fall.
// - Works with either idle clock polarity.
// - Page is 256 or 264 bytes, default 264.
// - Main array holds 1024 pages.
// - Program and erase cycles timed internally.
// - One page buffer accepts data during programming.
// - Direct program of one to page bytes.
// - 128-byte security area, 64 bytes user writable.
package sfe_pkg;
   // ---------------------------------------------------------------
   // Framing and states.
   // ---------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BYTES = 3;
   typedef enum logic [1:0] {
      SFE_IDLE = 2'b00,
      SFE_CMD = 2'b01,
      SFE_ADDR = 2'b11,
      SFE_DATA = 2'b10
   } sfe_state_type;
   // ---------------------------------------------------------------
   // Array organisation.
   // ---------------------------------------------------------------
   localparam int PAGES = 1024;
   localparam logic [8:0] PAGE_LONG = 9'h108;
   localparam logic [8:0] PAGE_SHORT = 9'h100;
   localparam logic PAGE_256_RESET = 1'b0;
   localparam int SEC_BYTES = 128;
   localparam logic [6:0] SEC_USER_BASE = 7'h40;
   // ---------------------------------------------------------------
   // Buffering and timing.
   // ---------------------------------------------------------------
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_MHZ = 100;
   localparam int PROG_TIME_US = 3000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
endpackage

// *** sfe_stream_if.sv ***
/*
   Valid/ready byte stream between the front end and its FIFO.
   Assumes both ends share one clock.
*/
interface sfe_stream_if;
   logic valid;
   logic ready;
   logic [sfe_pkg::FIFO_WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** testbench.sv ***
/*
   Self-checking bench for sfe_front_end with a link host model.
   Assumes a shortened timed cycle of 20 clocks.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0;
   logic i_resetn, i_cfg_256, i_timed_op, i_rx_ready;
   logic [7:0] i_tx_data;
   logic sel_n, sck, si, so, so_oe, tx_req, cmd_valid, page_256, sec_user;
   logic rx_valid, overrun, busy, standby;
   logic [7:0] cmd, rx_data, r;
   logic [9:0] page;
   logic [8:0] col, prog_count;
   int bad_count = 0, n_checks = 0, n_cmd = 0, n_tx = 0, cyc = 0;
   // 100 MHz system clock.
   always #5 i_sys_clk = ~i_sys_clk;
   sfe_front_end #(.PROG_CYCLES(20)) sfe_front_end_inst (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sel_n(sel_n), .i_sck(sck), .i_si(si),
      .o_so(so), .o_so_oe(so_oe), .i_cfg_256(i_cfg_256), .i_timed_op(i_timed_op),
      .i_tx_data(i_tx_data), .o_tx_req(tx_req), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
      .o_page(page), .o_col(col), .o_page_256(page_256), .o_sec_user(sec_user),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(i_rx_ready),
      .o_overrun(overrun), .o_prog_count(prog_count), .o_busy(busy), .o_standby(standby));
   sfe_host_model sfe_host_model_inst (
      .i_sys_clk(i_sys_clk), .i_so(so), .o_sel_n(sel_n), .o_sck(sck), .o_si(si));
   // Counts opcode strobes and cuts a hang short.
   always @(posedge i_sys_clk) begin
      if (cmd_valid === 1'b1) n_cmd++;
      if (tx_req === 1'b1) n_tx++;
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   // Waits for a stream byte under a bound, compares and pops it.
   task automatic pop(input logic [7:0] exp);
      for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) @(posedge i_sys_clk);
      check(rx_data, exp, "stream byte");
      i_rx_ready <= 1'b1;
      @(posedge i_sys_clk) i_rx_ready <= 1'b0;
      // One more edge so the next look sees the buffer after the pop.
      @(posedge i_sys_clk);
   endtask
   task automatic t_reset();
      check({so_oe, busy, standby, page_256}, 4'h2, "reset state");
   endtask
   task automatic t_desel();
      int c0;
      c0 = n_cmd;
      sfe_host_model_inst.wiggle(32);
      check(n_cmd, c0, "strobe while deselected");
      check({rx_valid, so_oe}, 2'h0, "deselected outputs");
   endtask
   // Mode 0 timed frame into the user security window.
   task automatic t_mode0();
      @(posedge i_sys_clk) i_tx_data <= 8'h3C;
      i_timed_op <= 1'b1;
      sfe_host_model_inst.frame_start(1'b0);
      sfe_host_model_inst.xfer(8'hA5, r);
      repeat (2) @(posedge i_sys_clk);
      check(n_cmd, 1, "one opcode");
      check(cmd, 8'hA5, "opcode");
      sfe_host_model_inst.xfer(8'h00, r);
      sfe_host_model_inst.xfer(8'h00, r);
      sfe_host_model_inst.xfer(8'h41, r);
      sfe_host_model_inst.xfer(8'h50, r);
      check(r, 8'h3C, "shifted out byte");
      sfe_host_model_inst.xfer(8'h51, r);
      repeat (2) @(posedge i_sys_clk);
      check({page, col}, {10'h000, 9'h043}, "page and column");
      check({sec_user, prog_count}, {1'b1, 9'h002}, "window and count");
      sfe_host_model_inst.frame_end(1'b0);
      i_timed_op <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      check({busy, standby}, 2'h2, "busy after frame");
      check(n_tx, 6, "launch loads");
      pop(8'h50);
      pop(8'h51);
      for (int i = 0; i < 60 && standby !== 1'b1; i++) @(posedge i_sys_clk);
      check({busy, standby}, 2'h1, "standby after cycle");
   endtask
   // Mode 3 frame in 256 mode that overfills the stream buffer.
   task automatic t_mode3();
      @(posedge i_sys_clk) i_cfg_256 <= 1'b1;
      @(posedge i_sys_clk) i_cfg_256 <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      check(page_256, 1'b1, "page mode set");
      sfe_host_model_inst.frame_start(1'b1);
      sfe_host_model_inst.xfer(8'h0B, r);
      sfe_host_model_inst.xfer(8'h00, r);
      sfe_host_model_inst.xfer(8'h03, r);
      sfe_host_model_inst.xfer(8'hFE, r);
      check(cmd, 8'h0B, "mode 3 opcode");
      for (int i = 0; i < 17; i++) sfe_host_model_inst.xfer(8'h60 + i[7:0], r);
      sfe_host_model_inst.frame_end(1'b1);
      check(page, 10'h003, "short page index");
      check({col, prog_count}, {9'h00F, 9'h011}, "column wrap and count");
      check(overrun, 1'b1, "buffer overrun");
      for (int i = 0; i < 16; i++) pop(8'h60 + i[7:0]);
      @(posedge i_sys_clk);
      check(rx_valid, 1'b0, "buffer empty");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence: reset for 4 cycles, then the scenarios.
   initial begin
      i_resetn <= 1'b0;
      i_cfg_256 <= 1'b0;
      i_timed_op <= 1'b0;
      i_rx_ready <= 1'b0;
      i_tx_data <= 8'h00;
      repeat (4) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      t_reset();
      t_desel();
      t_mode0();
      t_mode3();
      final_report();
   end
endmodule
